// ===== hdl/sfs_stats.sv
// Purpose: per-flow, per-identifier and signalling statistics counters
// Assumes: events arrive on the same clock; one read port per table
// Notes:   counters wrap at their width and clear on reset
//
// Summary of operation
// - count each data pdu forwarded to outgoing flow
// - count upstream pdus on scheduled flow slot
// - management messages never enter packet counter
// - grant violators count only on primary flow
// - unclassified upstream data credits primary flow; code credits unclassified incoming data, ignoring is_modem
// - include shaped packets, exclude policer drops
// - add post-header-check bytes for counted packets
// - flows keyed by nonzero 32-bit identifier
// - latch uptime into creation timestamp
// - active seconds counter per active flow
// - policer drops: buffer overflow, grant-policy drops
// - other drops on outgoing classified traffic go to outbound discard counter
// - policer drops read zero for incoming flows
// - shaper delays zero for grant and incoming
// - upstream stats ignore frames with fcs error
// - count every fragmentation header received
// - count every discarded upstream fragment
// - count every concatenation header received
// - two signalling sets, tagged by direction
// - headend: transmit is downstream, receive upstream
// - modem: receive is downstream, transmit upstream
// - addition requests count every retry too
`timescale 1ns/100ps
`default_nettype none

module sfs_stats
  import sfs_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // configuration
  input  wire logic                  is_modem,          // low: headend, high: modem
  input  wire logic [FLOW_IDX_W-1:0] primary_slot,      // primary upstream flow slot
  input  wire logic [31:0]           sys_uptime,        // system uptime value
  // event inputs
  input  wire sfs_ctl_t              flow_ctl,          // flow create and remove
  input  wire sfs_pkt_t              pkt_evt,           // packet path event
  input  wire sfs_us_t               us_evt,            // upstream header event
  input  wire logic                  add_req_evt,       // addition request seen
  input  wire logic                  add_req_tx,        // high: sent by this unit
  // read selects
  input  wire logic [FLOW_IDX_W-1:0] flow_rd_slot,      // flow table read index
  input  wire logic [SID_IDX_W-1:0]  sid_rd_slot,       // identifier read index
  // flow table read data
  output logic [31:0]                flow_identifier,   // key of selected flow
  output logic [63:0]                pkt_count,         // packets
  output logic [63:0]                octet_count,       // octets
  output logic [31:0]                created_stamp,     // creation uptime
  output logic [31:0]                active_seconds,    // seconds active
  output logic [31:0]                policer_drop_count,
  output logic [31:0]                shaper_delay_count,
  output logic                       flow_valid,        // slot holds a live flow
  // identifier table read data
  output logic [31:0]                fragment_count,
  output logic [31:0]                discarded_fragment_count,
  output logic [31:0]                concat_header_count,
  // interface discards and signalling sets
  output logic [31:0]                out_discard_count, // outbound discards
  output logic [31:0]                add_request_count_down,
  output logic [31:0]                add_request_count_up,
  output sfs_dir_t                   direction_selector_down,
  output sfs_dir_t                   direction_selector_up
);

  // flow table storage
  logic [31:0] fid     [FLOW_SLOTS];              // identifier per slot
  logic [63:0] pkts    [FLOW_SLOTS];              // packet counters
  logic [63:0] octs    [FLOW_SLOTS];              // octet counters
  logic [31:0] created [FLOW_SLOTS];              // timestamps
  logic [31:0] active  [FLOW_SLOTS];              // active seconds
  logic [31:0] drops   [FLOW_SLOTS];              // policer drops
  logic [31:0] delays  [FLOW_SLOTS];              // shaper delays
  logic [FLOW_SLOTS-1:0] live;                    // slot in use
  logic [FLOW_SLOTS-1:0] outg;                    // slot is outgoing
  logic [FLOW_SLOTS-1:0] unsolicited_grant_service;                     // slot is grant service

  // identifier table storage
  logic [31:0] frags   [SID_SLOTS];               // fragment headers
  logic [31:0] fdisc   [SID_SLOTS];               // discarded fragments
  logic [31:0] concs   [SID_SLOTS];               // concatenation headers

  // one-second tick counter
  logic [26:0] sec_cnt;                           // cycle count within a second
  logic        sec_tick;                          // one-cycle tick

  // packet decode results
  logic [FLOW_IDX_W-1:0] cnt_slot;                // slot credited for the packet
  logic                  is_drop;                 // policer drop case
  logic                  is_count;                // packet counter case

  // seconds tick; free running since the count is coarse anyway
  always_ff @(posedge clock) begin
    if (rst) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b0;
    end else if (sec_cnt == 27'(SECOND_CYC - 1)) begin
      sec_cnt  <= '0;
      sec_tick <= 1'b1;
    end else begin
      sec_cnt  <= sec_cnt + 27'h1;
      sec_tick <= 1'b0;
    end
  end

  // packet classification into count, drop or neither
  always_comb begin
    // unclassified incoming data lands on the primary flow
    cnt_slot = pkt_evt.slot;
    if (!pkt_evt.outgoing && !pkt_evt.classified) begin
      cnt_slot = primary_slot;
    end
    if (pkt_evt.grant_violation && !pkt_evt.policy_drop) begin
      cnt_slot = primary_slot;
    end
    // policer drops only on outgoing classified traffic
    is_drop  = pkt_evt.valid && pkt_evt.outgoing && pkt_evt.classified && !pkt_evt.mgmt
               && (pkt_evt.buffer_drop
                   || (pkt_evt.grant_violation && pkt_evt.policy_drop));
    // counted when data, not a policer drop or other drop; shaped still counts
    is_count = pkt_evt.valid && !pkt_evt.mgmt && !is_drop && !pkt_evt.other_drop
               && live[cnt_slot];
  end

  // flow creation, identity and direction bookkeeping
  always_ff @(posedge clock) begin
    if (rst) begin
      live <= '0;
      outg <= '0;
      unsolicited_grant_service  <= '0;
      for (int i = 0; i < FLOW_SLOTS; i++) begin
        fid[i]     <= ZERO32;
        created[i] <= ZERO32;
      end
    end else if (flow_ctl.create && flow_ctl.flow_identifier != ZERO32) begin
      // zero is never a legal key, so this block ignores such a create; the counter blocks do not
      live[flow_ctl.slot]    <= 1'b1;
      fid[flow_ctl.slot]     <= flow_ctl.flow_identifier;
      outg[flow_ctl.slot]    <= flow_ctl.outgoing;
      unsolicited_grant_service[flow_ctl.slot]     <= flow_ctl.grant_service;
      created[flow_ctl.slot] <= sys_uptime;
    end else if (flow_ctl.remove) begin
      live[flow_ctl.slot] <= 1'b0;
    end
  end

  // per-flow packet and octet counters, wrapping at 64 bits
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < FLOW_SLOTS; i++) begin
        pkts[i] <= ZERO64;
        octs[i] <= ZERO64;
      end
    end else if (flow_ctl.create) begin
      pkts[flow_ctl.slot] <= ZERO64;              // fresh flow starts clean
      octs[flow_ctl.slot] <= ZERO64;
    end else if (is_count) begin
      pkts[cnt_slot] <= pkts[cnt_slot] + 64'h1;
      octs[cnt_slot] <= octs[cnt_slot] + 64'(pkt_evt.octets);
    end
  end

  // active seconds, one step per tick while live
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < FLOW_SLOTS; i++) active[i] <= ZERO32;
    end else begin
      for (int i = 0; i < FLOW_SLOTS; i++) begin
        if (flow_ctl.create && flow_ctl.slot == FLOW_IDX_W'(i)) begin
          active[i] <= ZERO32;
        end else if (sec_tick && live[i]) begin
          active[i] <= active[i] + 32'h1;
        end
      end
    end
  end

  // policer drops and shaper delays, outgoing flows only
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < FLOW_SLOTS; i++) begin
        drops[i]  <= ZERO32;
        delays[i] <= ZERO32;
      end
    end else if (flow_ctl.create) begin
      drops[flow_ctl.slot]  <= ZERO32;
      delays[flow_ctl.slot] <= ZERO32;
    end else begin
      if (is_drop && live[pkt_evt.slot] && outg[pkt_evt.slot]) begin
        drops[pkt_evt.slot] <= drops[pkt_evt.slot] + 32'h1;
      end
      // grant flows have no sustained rate, so never shaped
      if (is_count && pkt_evt.shaped && outg[cnt_slot] && !unsolicited_grant_service[cnt_slot]) begin
        delays[cnt_slot] <= delays[cnt_slot] + 32'h1;
      end
    end
  end

  // outbound discards for drops the policer does not own
  always_ff @(posedge clock) begin
    if (rst) begin
      out_discard_count <= ZERO32;
    end else if (pkt_evt.valid && pkt_evt.outgoing && pkt_evt.classified
                 && pkt_evt.other_drop && !is_drop) begin
      out_discard_count <= out_discard_count + 32'h1;
    end
  end

  // upstream header counters, good frames only
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < SID_SLOTS; i++) begin
        frags[i] <= ZERO32;
        fdisc[i] <= ZERO32;
        concs[i] <= ZERO32;
      end
    end else if (us_evt.valid && us_evt.fcs_ok) begin
      if (us_evt.frag_hdr) begin
        frags[us_evt.slot] <= frags[us_evt.slot] + 32'h1;
      end
      if (us_evt.frag_discard) begin
        fdisc[us_evt.slot] <= fdisc[us_evt.slot] + 32'h1;
      end
      if (us_evt.concat_hdr) begin
        concs[us_evt.slot] <= concs[us_evt.slot] + 32'h1;
      end
    end
  end

  // signalling counters: direction follows the unit's role
  always_ff @(posedge clock) begin
    if (rst) begin
      add_request_count_down <= ZERO32;
      add_request_count_up   <= ZERO32;
    end else if (add_req_evt) begin
      // headend sends downstream; modem sends upstream
      if (add_req_tx ^ is_modem) begin
        add_request_count_down <= add_request_count_down + 32'h1;
      end else begin
        add_request_count_up <= add_request_count_up + 32'h1;
      end
    end
  end

  // direction tags are fixed per set
  always_ff @(posedge clock) begin
    direction_selector_down <= SFS_DIR_DOWN;
    direction_selector_up   <= SFS_DIR_UP;
  end

  // registered read ports; incoming flows report zero drops and delays
  always_ff @(posedge clock) begin
    if (rst) begin
      flow_identifier          <= ZERO32;
      pkt_count                <= ZERO64;
      octet_count              <= ZERO64;
      created_stamp            <= ZERO32;
      active_seconds           <= ZERO32;
      policer_drop_count       <= ZERO32;
      shaper_delay_count       <= ZERO32;
      flow_valid               <= 1'b0;
      fragment_count           <= ZERO32;
      discarded_fragment_count <= ZERO32;
      concat_header_count      <= ZERO32;
    end else begin
      flow_identifier    <= fid[flow_rd_slot];
      pkt_count          <= pkts[flow_rd_slot];
      octet_count        <= octs[flow_rd_slot];
      created_stamp      <= created[flow_rd_slot];
      active_seconds     <= active[flow_rd_slot];
      policer_drop_count <= outg[flow_rd_slot] ? drops[flow_rd_slot] : ZERO32;
      shaper_delay_count <= (outg[flow_rd_slot] && !unsolicited_grant_service[flow_rd_slot])
                            ? delays[flow_rd_slot] : ZERO32;
      flow_valid               <= live[flow_rd_slot];
      fragment_count           <= frags[sid_rd_slot];
      discarded_fragment_count <= fdisc[sid_rd_slot];
      concat_header_count      <= concs[sid_rd_slot];
    end
  end

  // checks
  // sampled reset keeps an attempt out of the release edge, where state is still held clear
  sequence s_counted_pkt;
    !rst && is_count && !flow_ctl.create;
  endsequence
  sequence s_good_frag;
    !rst && us_evt.valid && us_evt.fcs_ok && us_evt.frag_hdr;
  endsequence
  a_mgmt_not_counted: assert property (@(posedge clock) disable iff (rst)
    (pkt_evt.valid && pkt_evt.mgmt && !flow_ctl.create)
    |=> pkts[$past(cnt_slot)] == $past(pkts[cnt_slot]))
    else $error("management message changed packet count");
  a_fcs_bad_ignored: assert property (@(posedge clock) disable iff (rst)
    (us_evt.valid && !us_evt.fcs_ok)
    |=> frags[$past(us_evt.slot)] == $past(frags[us_evt.slot]))
    else $error("fragment count moved on bad fcs");
  a_drop_read_zero: assert property (@(posedge clock) disable iff (rst)
    !outg[flow_rd_slot] |=> policer_drop_count == ZERO32)
    else $error("incoming flow shows policer drops");
  a_delay_read_zero: assert property (@(posedge clock) disable iff (rst)
    unsolicited_grant_service[flow_rd_slot] |=> shaper_delay_count == ZERO32)
    else $error("grant flow shows shaper delays");
  a_create_stamp: assert property (@(posedge clock) disable iff (rst)
    (flow_ctl.create && flow_ctl.flow_identifier != ZERO32)
    |=> created[$past(flow_ctl.slot)] == $past(sys_uptime))
    else $error("creation stamp not latched");
  a_tick_spacing: assert property (@(posedge clock) disable iff (rst)
    sec_tick |=> !sec_tick [*8])
    else $error("seconds tick too frequent");
  a_discard_step: assert property (@(posedge clock) disable iff (rst)
    (pkt_evt.valid && pkt_evt.outgoing && pkt_evt.classified && pkt_evt.other_drop
     && !is_drop) |=> out_discard_count == $past(out_discard_count) + 32'h1)
    else $error("outbound discard not counted");
  a_add_req_step: assert property (@(posedge clock) disable iff (rst)
    add_req_evt |=> (add_request_count_down + add_request_count_up)
      == ($past(add_request_count_down) + $past(add_request_count_up) + 32'h1))
    else $error("addition request lost");
  // the credited slot steps by one packet and by that packet's length
  a_pkt_step: assert property (@(posedge clock) disable iff (rst)
    s_counted_pkt |=> pkts[$past(cnt_slot)] == $past(pkts[cnt_slot]) + 64'h1)
    else $error("counted packet did not step the packet count");
  a_octet_step: assert property (@(posedge clock) disable iff (rst)
    s_counted_pkt |=> octs[$past(cnt_slot)]
      == $past(octs[cnt_slot]) + 64'($past(pkt_evt.octets)))
    else $error("octet count did not add the packet length");
  // policer drops land on the packet's own outgoing slot
  a_drop_step: assert property (@(posedge clock) disable iff (rst)
    (!rst && is_drop && !flow_ctl.create && live[pkt_evt.slot] && outg[pkt_evt.slot])
    |=> drops[$past(pkt_evt.slot)] == $past(drops[pkt_evt.slot]) + 32'h1)
    else $error("policer drop not counted");
  // good fragment headers always step their identifier slot
  a_frag_step: assert property (@(posedge clock) disable iff (rst)
    s_good_frag |=> frags[$past(us_evt.slot)] == $past(frags[us_evt.slot]) + 32'h1)
    else $error("fragment header not counted");
  // tick counter moves by one per cycle and ticks only at the wrap; runs are too short to see a tick
  a_tick_step: assert property (@(posedge clock) disable iff (rst)
    !rst && sec_cnt != 27'(SECOND_CYC - 1)
    |=> !sec_tick && sec_cnt == $past(sec_cnt) + 27'h1)
    else $error("seconds tick counter skipped");

endmodule

`default_nettype wire

// ===== hdl/sfs_pkg.sv
// Purpose: shared constants and carrier types for the flow statistics block
// Assumes: one clock, synchronous active-high reset
// Notes:   table sizes are small fixed figures chosen for this block
package sfs_pkg;

  // table sizes
  localparam int FLOW_SLOTS   = 8;               // per-flow table entries
  localparam int FLOW_IDX_W   = 3;               // slot index width
  localparam int SID_SLOTS    = 8;               // upstream identifier entries
  localparam int SID_IDX_W    = 3;               // identifier slot width
  localparam int LEN_W        = 16;              // packet length field width

  // timing: one active-second tick per second at 100 MHz
  localparam int CLOCK_HZ     = 100000000;       // clock rate in hertz
  localparam int SECOND_MS    = 1000;            // active tick period in ms
  localparam int SECOND_CYC   = CLOCK_HZ / 1000 * SECOND_MS;  // cycles per tick

  // reset values
  localparam logic [63:0] ZERO64 = 64'h0;        // wide counter reset value
  localparam logic [31:0] ZERO32 = 32'h0;        // narrow counter reset value

  // direction tags for the signalling sets
  typedef enum logic {SFS_DIR_DOWN, SFS_DIR_UP} sfs_dir_t;

  // packet event from the packet path
  typedef struct packed {
    logic                  valid;                // one-cycle event strobe
    logic [FLOW_IDX_W-1:0] slot;                 // flow slot the packet maps to
    logic                  outgoing;             // flow direction: outgoing
    logic                  mgmt;                 // mac management message
    logic                  classified;           // matched a classifier
    logic                  grant_violation;      // exceeded unsolicited grant size
    logic                  policy_drop;          // policy demands drop of violators
    logic                  buffer_drop;          // buffer size exceeded
    logic                  other_drop;           // dropped for another reason
    logic                  shaped;               // held back by rate shaper
    logic [LEN_W-1:0]      octets;               // bytes after header check to crc
  } sfs_pkt_t;

  // upstream burst header event
  typedef struct packed {
    logic                 valid;                 // one-cycle event strobe
    logic [SID_IDX_W-1:0] slot;                  // identifier slot
    logic                 fcs_ok;                // frame check sequence correct
    logic                 frag_hdr;              // fragmentation header seen
    logic                 frag_discard;          // fragment thrown away
    logic                 concat_hdr;            // concatenation header seen
  } sfs_us_t;

  // flow control event
  typedef struct packed {
    logic                  create;               // flow created this cycle
    logic                  remove;               // flow removed this cycle
    logic [FLOW_IDX_W-1:0] slot;                 // slot affected
    logic [31:0]           flow_identifier;      // nonzero key given to the flow
    logic                  outgoing;             // direction of new flow
    logic                  grant_service;        // unsolicited grant flow
  } sfs_ctl_t;

endpackage

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the flow statistics counters
// Assumes: one 100 MHz clock, synchronous active-high reset held 10 cycles
// Notes:   the one-second activity tick lies far beyond this run, so it must read zero
`timescale 1ns/100ps
`default_nettype none

module tb_top
  import sfs_pkg::*;
;
  // packet flags, packed in the order of the event struct
  localparam logic [7:0] F_OUT = 8'h80;  // outgoing flow
  localparam logic [7:0] F_MGT = 8'h40;  // management message
  localparam logic [7:0] F_CLS = 8'h20;  // classified
  localparam logic [7:0] F_GV  = 8'h10;  // grant size violation
  localparam logic [7:0] F_POL = 8'h08;  // policy says drop violators
  localparam logic [7:0] F_BUF = 8'h04;  // buffer overflow drop
  localparam logic [7:0] F_OTH = 8'h02;  // dropped for another reason
  localparam logic [7:0] F_SHP = 8'h01;  // held by rate shaper

  // stimulus, all given a value at time zero
  logic                  clock        = 1'b0;
  logic                  rst          = 1'b1;
  logic                  is_modem     = 1'b0;   // start as headend
  logic [FLOW_IDX_W-1:0] primary_slot = 3'h3;   // primary upstream flow
  logic [31:0]           sys_uptime   = 32'h0;
  sfs_ctl_t              flow_ctl     = '0;
  sfs_pkt_t              pkt_evt      = '0;
  sfs_us_t               us_evt       = '0;
  logic                  add_req_evt  = 1'b0;
  logic                  add_req_tx   = 1'b0;
  logic [FLOW_IDX_W-1:0] flow_rd_slot = 3'h0;
  logic [SID_IDX_W-1:0]  sid_rd_slot  = 3'h0;
  // observed outputs
  logic [31:0] flow_identifier, created_stamp, active_seconds, policer_drop_count;
  logic [31:0] shaper_delay_count, fragment_count, discarded_fragment_count;
  logic [31:0] concat_header_count, out_discard_count;
  logic [31:0] add_request_count_down, add_request_count_up;
  logic [63:0] pkt_count, octet_count;
  logic        flow_valid;
  sfs_dir_t    direction_selector_down, direction_selector_up;
  // bookkeeping
  int          err_total = 0;
  int          cmp_count = 0;

  // free-running clock, 10 ns period
  always #5 clock = ~clock;

  sfs_stats u_dut (
    .clock(clock), .rst(rst), .is_modem(is_modem), .primary_slot(primary_slot),
    .sys_uptime(sys_uptime), .flow_ctl(flow_ctl), .pkt_evt(pkt_evt), .us_evt(us_evt),
    .add_req_evt(add_req_evt), .add_req_tx(add_req_tx), .flow_rd_slot(flow_rd_slot),
    .sid_rd_slot(sid_rd_slot), .flow_identifier(flow_identifier), .pkt_count(pkt_count),
    .octet_count(octet_count), .created_stamp(created_stamp),
    .active_seconds(active_seconds), .policer_drop_count(policer_drop_count),
    .shaper_delay_count(shaper_delay_count), .flow_valid(flow_valid),
    .fragment_count(fragment_count), .discarded_fragment_count(discarded_fragment_count),
    .concat_header_count(concat_header_count), .out_discard_count(out_discard_count),
    .add_request_count_down(add_request_count_down),
    .add_request_count_up(add_request_count_up),
    .direction_selector_down(direction_selector_down),
    .direction_selector_up(direction_selector_up)
  );

  // single comparison point; case inequality so unknowns never match
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // create pulse; uptime is inverted afterwards so a late latch shows
  task automatic make_flow(input logic [2:0] s, input logic [31:0] id, input logic out,
                           input logic gs, input logic [31:0] up);
    @(posedge clock);
    flow_ctl   <= '{create: 1'b1, remove: 1'b0, slot: s, flow_identifier: id,
                    outgoing: out, grant_service: gs};
    sys_uptime <= up;
    @(posedge clock);
    flow_ctl   <= '0;
    sys_uptime <= ~up;
  endtask

  // one packet event; the idle cycle after it keeps drivers single per step
  task automatic send_pkt(input logic [2:0] s, input logic [7:0] f, input logic [15:0] n);
    @(posedge clock);
    pkt_evt <= sfs_pkt_t'({1'b1, s, f, n});
    @(posedge clock);
    pkt_evt <= '0;
  endtask

  // upstream header event, flags are fcs_ok, frag, discard, concat
  task automatic send_us(input logic [2:0] s, input logic [3:0] f);
    @(posedge clock);
    us_evt <= sfs_us_t'({1'b1, s, f});
    @(posedge clock);
    us_evt <= '0;
  endtask

  // addition request seen, tx high when this unit sent it
  task automatic send_add(input logic tx);
    @(posedge clock);
    add_req_evt <= 1'b1;
    add_req_tx  <= tx;
    @(posedge clock);
    add_req_evt <= 1'b0;
  endtask

  // read one flow slot; outputs settle one edge after the select, checked after two
  task automatic rd_flow(input logic [2:0] s, input logic v, input logic [31:0] id,
                         input logic [63:0] pk, input logic [63:0] oc,
                         input logic [31:0] st, input logic [31:0] pd, input logic [31:0] sd);
    @(posedge clock);
    flow_rd_slot <= s;
    repeat (2) @(posedge clock);
    #1;
    chk("flow_valid", 64'(flow_valid), 64'(v));
    chk("flow_identifier", 64'(flow_identifier), 64'(id));
    chk("pkt_count", pkt_count, pk);
    chk("octet_count", octet_count, oc);
    chk("created_stamp", 64'(created_stamp), 64'(st));
    chk("active_seconds", 64'(active_seconds), 64'h0);
    chk("policer_drop_count", 64'(policer_drop_count), 64'(pd));
    chk("shaper_delay_count", 64'(shaper_delay_count), 64'(sd));
  endtask

  // read one upstream identifier slot
  task automatic rd_sid(input logic [2:0] s, input logic [31:0] fr, input logic [31:0] fd,
                        input logic [31:0] ch);
    @(posedge clock);
    sid_rd_slot <= s;
    repeat (2) @(posedge clock);
    #1;
    chk("fragment_count", 64'(fragment_count), 64'(fr));
    chk("discarded_fragment_count", 64'(discarded_fragment_count), 64'(fd));
    chk("concat_header_count", 64'(concat_header_count), 64'(ch));
  endtask

  // interface-wide counters
  task automatic rd_glob(input logic [31:0] od, input logic [31:0] dn, input logic [31:0] up);
    repeat (2) @(posedge clock);
    #1;
    chk("out_discard_count", 64'(out_discard_count), 64'(od));
    chk("add_request_count_down", 64'(add_request_count_down), 64'(dn));
    chk("add_request_count_up", 64'(add_request_count_up), 64'(up));
  endtask

  // verdict, reached from the main sequence or the watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("direction_selector_down", 64'(direction_selector_down), 64'(SFS_DIR_DOWN));
    chk("direction_selector_up", 64'(direction_selector_up), 64'(SFS_DIR_UP));
    rd_glob(32'h0, 32'h0, 32'h0);
    rd_flow(3'h2, 1'b0, 32'h0, 64'h0, 64'h0, 32'h0, 32'h0, 32'h0);
    $display("test reset done");
    // flows: outgoing, primary incoming, incoming, outgoing grant, zero key
    make_flow(3'h2, 32'h5, 1'b1, 1'b0, 32'h1234);
    make_flow(3'h3, 32'h7, 1'b0, 1'b0, 32'h2000);
    make_flow(3'h4, 32'h9, 1'b0, 1'b0, 32'h3000);
    make_flow(3'h5, 32'hB, 1'b1, 1'b1, 32'h4000);
    make_flow(3'h6, 32'h0, 1'b1, 1'b0, 32'h5000);
    send_pkt(3'h2, F_OUT | F_CLS, 16'h0064);
    send_pkt(3'h2, F_OUT | F_CLS | F_SHP, 16'h003C);
    send_pkt(3'h2, F_OUT | F_MGT | F_CLS, 16'h0028);
    send_pkt(3'h2, F_OUT | F_CLS | F_BUF, 16'h001E);
    send_pkt(3'h2, F_OUT | F_CLS | F_OTH, 16'h000A);
    send_pkt(3'h5, F_OUT | F_CLS | F_GV | F_POL, 16'h0014);
    send_pkt(3'h5, F_OUT | F_CLS | F_SHP, 16'h0032);
    send_pkt(3'h5, F_OUT | F_CLS | F_GV, 16'h0046);
    send_pkt(3'h4, F_CLS, 16'h0050);
    send_pkt(3'h4, 8'h00, 16'h005A);
    send_pkt(3'h4, F_CLS | F_SHP, 16'h000A);
    send_pkt(3'h4, F_CLS | F_BUF, 16'h0005);
    rd_flow(3'h2, 1'b1, 32'h5, 64'h2, 64'hA0, 32'h1234, 32'h1, 32'h1);
    rd_flow(3'h5, 1'b1, 32'hB, 64'h1, 64'h32, 32'h4000, 32'h1, 32'h0);
    rd_flow(3'h4, 1'b1, 32'h9, 64'h3, 64'h5F, 32'h3000, 32'h0, 32'h0);
    rd_flow(3'h3, 1'b1, 32'h7, 64'h2, 64'hA0, 32'h2000, 32'h0, 32'h0);
    rd_flow(3'h6, 1'b0, 32'h0, 64'h0, 64'h0, 32'h0, 32'h0, 32'h0);
    rd_glob(32'h1, 32'h0, 32'h0);
    $display("test flow counters done");
    // upstream headers, the last frame on slot 1 carries a bad fcs
    send_us(3'h1, 4'hC);
    send_us(3'h1, 4'hE);
    send_us(3'h1, 4'h9);
    send_us(3'h1, 4'h7);
    send_us(3'h2, 4'hD);
    rd_sid(3'h1, 32'h2, 32'h1, 32'h1);
    rd_sid(3'h2, 32'h1, 32'h0, 32'h1);
    $display("test upstream headers done");
    // signalling sets: headend then modem, retries included
    send_add(1'b1);
    send_add(1'b1);
    send_add(1'b0);
    rd_glob(32'h1, 32'h2, 32'h1);
    @(posedge clock);
    is_modem <= 1'b1;
    send_add(1'b1);
    send_add(1'b0);
    rd_glob(32'h1, 32'h3, 32'h2);
    $display("test signalling done");
    // reinitialization in mid-run clears everything
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd_glob(32'h0, 32'h0, 32'h0);
    rd_flow(3'h2, 1'b0, 32'h0, 64'h0, 64'h0, 32'h0, 32'h0, 32'h0);
    rd_sid(3'h1, 32'h0, 32'h0, 32'h0);
    $display("test second reset done");
    tally_and_finish();
  end

  // watchdog, the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    $display("[FAIL] watchdog expected finish seen hang");
    tally_and_finish();
  end

endmodule

`default_nettype wire
